// >>> hdl/gate_fine_shift.sv
// Purpose: delays a gate by zero to three enable periods
// Assumes: shift setting is static while the gate runs
// Notes: both edges move together since the whole level is delayed
`timescale 1ns/1ps
module gate_fine_shift (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic d,
    input wire logic [1:0] shift,
    output logic q
);
    typedef struct packed {
        logic [2:0] pipe;
        logic q;
    } st_t;
    st_t s_q, s_d;
    logic [3:0] taps;

    assign taps = {s_q.pipe, d};

    always_comb begin
        s_d = s_q;
        if (ce) begin
            s_d.pipe = {s_q.pipe[1:0], d};
            s_d.q = taps[shift];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.q;

    a_shift_zero: assert property (@(posedge mclk) disable iff (!resetn)
        ce && shift == 2'h0 |=> q == $past(d))
        else $error("zero shift did not pass gate straight");
endmodule : gate_fine_shift

// >>> hdl/set_clear_pulse.sv
// Purpose: one programmable set/clear pulse generator
// Assumes: compares act only on enable cycles
// Notes: equal set and clear values keep the output low while clr_ok is set
`timescale 1ns/1ps
module set_clear_pulse (
    input wire logic mclk,
    input wire logic resetn,
    srp_if.gen p
);
    typedef struct packed {
        logic q;
    } st_t;
    st_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (p.ce) begin
            if (p.clr_ok && p.count == p.clr_val) begin
                s_d.q = 1'b0;
            end else if (p.set_ok && p.count == p.set_val) begin
                s_d.q = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign p.q = s_q.q;

    a_clear_wins: assert property (@(posedge mclk) disable iff (!resetn)
        p.ce && p.clr_ok && p.count == p.clr_val |=> !p.q)
        else $error("clear compare did not clear output");
endmodule : set_clear_pulse

// >>> hdl/srp_if.sv
// Purpose: carrier between timing core and one set/clear generator
// Assumes: count and compares share one width
// Notes: ok terms gate the compares, clear beats set inside generator
`timescale 1ns/1ps
interface srp_if #(parameter int W = 8);
    logic ce;
    logic [W-1:0] count;
    logic [W-1:0] set_val;
    logic [W-1:0] clr_val;
    logic set_ok;
    logic clr_ok;
    logic q;
    modport gen(input ce, count, set_val, clr_val, set_ok, clr_ok,
                output q);
    modport user(output ce, count, set_val, clr_val, set_ok, clr_ok,
                 input q);
endinterface : srp_if

// >>> hdl/vid_timing_pkg.sv
// Purpose: shared constants for the video sync timing generator
// Assumes: one mclk domain, acquisition and display rates as enables
// Notes: bus addresses are decoded on the latched address byte, the acquisition compare on its low seven bits only
package vid_timing_pkg;
    localparam int PIX_W = 8;
    localparam int LINE_W = 9;
    localparam int SHIFT_W = 2;
    localparam int N_ACQ_GATE = 3;
    // display set/clear pairs: mute, sync, frame key x3, disp gate x2
    localparam int N_DISP_SRP = 7;
    localparam int SRP_MUTE = 0;
    localparam int SRP_SYNC = 1;
    localparam int SRP_KEY0 = 2;
    localparam int SRP_GATE0 = 5;
    localparam int N_IRQ = 4;
    localparam int IRQ_ACQ_LINE = 0;
    localparam int IRQ_GATE = 1;
    localparam int IRQ_OVL = 2;
    localparam int IRQ_DISP = 3;
    localparam logic [3:0] IRQ_ACQ_MASK = 4'h7;
    localparam logic [7:0] ADDR_DISP_LINE_RST = 8'h14;
    localparam logic [7:0] ADDR_SNAPSHOT = 8'h15;
    localparam logic [7:0] ADDR_PLL_CTRL = 8'h3d;
    localparam logic [7:0] ADDR_IRQ_CLR_BASE = 8'h30;
    localparam logic [6:0] ADDR_ACQ_IRQ_CMP = 7'h40;
    localparam int PLL_ACQ_LINE_IRQ_BIT = 1;
    localparam int PLL_OVL_IRQ_BIT = 2;
    localparam int PLL_GATE_IRQ_BIT = 3;
    localparam logic [7:0] PLL_CTRL_RST = 8'h00;
    localparam logic [8:0] ACQ_IRQ_CMP_RST = 9'h1ff;
endpackage : vid_timing_pkg

// >>> hdl/video_sync_timing_generator.sv
// Purpose: acquisition and display sync timing, captures and interrupts
// Assumes: acq_ce and disp_ce are one-cycle enables from clock dividers
// Notes: set/clear outputs lag their compares by two mclk, read strobe three at zero shift; timing values on ports, acquisition interrupt setup on the bus
`timescale 1ns/1ps
module video_sync_timing_generator #(
    parameter int PIX_W = vid_timing_pkg::PIX_W,
    parameter int LINE_W = vid_timing_pkg::LINE_W
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic acq_ce,
    input wire logic disp_ce,
    input wire logic ale,
    input wire logic [7:0] ad_in,
    input wire logic write_strobe_n,
    input wire logic acq_line_reset_pulse,
    input wire logic acq_field_pulse,
    input wire logic overlay_window_input,
    input wire logic disp_line_reset_pulse,
    input wire logic disp_field_pulse,
    input wire logic [PIX_W-1:0] acq_pix_term,
    input wire logic [PIX_W-1:0] acq_hpos,
    input wire logic [2:0][PIX_W-1:0] acq_gate_set,
    input wire logic [2:0][PIX_W-1:0] acq_gate_clr,
    input wire logic [LINE_W-1:0] acq_win_open,
    input wire logic [LINE_W-1:0] acq_win_close,
    input wire logic [LINE_W-1:0] gate_start_line,
    input wire logic [LINE_W-1:0] gate_stop_count,
    input wire logic [PIX_W-1:0] disp_pix_term,
    input wire logic [6:0][PIX_W-1:0] disp_set,
    input wire logic [6:0][PIX_W-1:0] disp_clr,
    input wire logic [6:0] disp_set_en,
    input wire logic [6:0] disp_clr_en,
    input wire logic [1:0] disp_gate_shift,
    input wire logic [LINE_W-1:0] disp_line_irq_cmp,
    output logic clamp_control_out,
    output logic field_mem_write_strobe,
    output logic field_mem_input_strobe,
    output logic acq_horizontal_pulse,
    output logic disp_horizontal_pulse,
    output logic video_mute_window,
    output logic disp_sync_output,
    output logic frame_key_window,
    output logic field_mem_read_strobe,
    output logic acq_irq_out,
    output logic disp_irq_out,
    output logic [PIX_W-1:0] acq_field_edge_position,
    output logic [LINE_W-1:0] acq_field_line_capture,
    output logic [PIX_W-1:0] disp_field_edge_position,
    output logic [LINE_W-1:0] disp_field_line_capture,
    output logic [PIX_W-1:0] overlay_rise_position,
    output logic [PIX_W-1:0] overlay_fall_position,
    output logic [3:0] interrupt_status_source
);
    generate
        if (PIX_W < 2 || PIX_W > 8 || LINE_W != 9) begin : g_bad
            $error("counter widths not supported by the 9-bit bus path");
        end
    endgenerate

    typedef struct packed {
        logic [PIX_W-1:0] acq_pix;
        logic [LINE_W-1:0] acq_line;
        logic [LINE_W-1:0] gate_cnt;
        logic gate_en;
        logic win;
        logic seen;
        logic r1_prev;
        logic vi1_prev;
        logic ovl_prev;
        logic r2_prev;
        logic vi2_prev;
        logic [PIX_W-1:0] disp_pix;
        logic [LINE_W-1:0] disp_line;
        logic hu;
        logic hi;
        logic [6:0] set_en;
        logic [6:0] clr_en;
        logic [2:0] gates;
        logic mute;
        logic sync;
        logic fkey;
        logic rdstb;
        logic [PIX_W-1:0] afep;
        logic [LINE_W-1:0] aflc;
        logic [PIX_W-1:0] dfep;
        logic [LINE_W-1:0] dflc;
        logic [PIX_W-1:0] orise;
        logic [PIX_W-1:0] ofall;
        logic [3:0] irq;
        logic [7:0] pll;
        logic [LINE_W-1:0] acq_cmp;
        logic [7:0] addr;
        logic wr_prev;
        logic it1;
        logic it2;
    } st_t;
    st_t s_q, s_d;

    logic wr;
    logic snap;
    logic [8:0] wdat9;
    logic r1_rise, vi1_rise, ovl_rise, ovl_fall, r2_rise, vi2_rise;
    logic acq_adv, disp_adv, vi1_hit;
    logic [2:0] acq_q;
    logic [6:0] disp_q;
    logic dgate_shifted;
    logic [3:0] irq_set, irq_clr;

    // write takes effect on the falling strobe edge, once per access
    assign wr = s_q.wr_prev && !write_strobe_n;
    assign wdat9 = {s_q.addr[7], ad_in};
    assign snap = wr && s_q.addr == vid_timing_pkg::ADDR_SNAPSHOT;
    assign r1_rise = acq_ce && acq_line_reset_pulse && !s_q.r1_prev;
    assign vi1_rise = acq_ce && acq_field_pulse && !s_q.vi1_prev;
    assign ovl_rise = acq_ce && overlay_window_input && !s_q.ovl_prev;
    assign ovl_fall = acq_ce && !overlay_window_input && s_q.ovl_prev;
    assign r2_rise = disp_ce && disp_line_reset_pulse && !s_q.r2_prev;
    assign vi2_rise = disp_ce && disp_field_pulse && !s_q.vi2_prev;
    assign acq_adv = r1_rise ||
        (acq_ce && s_q.acq_pix == acq_pix_term);
    assign disp_adv = r2_rise ||
        (disp_ce && s_q.disp_pix == disp_pix_term);
    // edges outside the vertical window are discarded
    assign vi1_hit = vi1_rise && s_q.win;

    srp_if #(.W(PIX_W)) acq_if[vid_timing_pkg::N_ACQ_GATE] ();
    srp_if #(.W(PIX_W)) disp_if[vid_timing_pkg::N_DISP_SRP] ();

    generate
        for (genvar i = 0; i < vid_timing_pkg::N_ACQ_GATE; i++) begin : g_acq
            assign acq_if[i].ce = acq_ce;
            assign acq_if[i].count = s_q.acq_pix;
            assign acq_if[i].set_val = acq_gate_set[i];
            assign acq_if[i].clr_val = acq_gate_clr[i];
            // later gates may only start inside the vertical gate
            assign acq_if[i].set_ok = (i == 0) ? 1'b1 : s_q.gate_en;
            assign acq_if[i].clr_ok = 1'b1;
            assign acq_q[i] = acq_if[i].q;
            set_clear_pulse u_gate (
                .mclk(mclk),
                .resetn(resetn),
                .p(acq_if[i])
            );
        end
        for (genvar j = 0; j < vid_timing_pkg::N_DISP_SRP; j++) begin : g_disp
            assign disp_if[j].ce = disp_ce;
            assign disp_if[j].count = s_q.disp_pix;
            assign disp_if[j].set_val = disp_set[j];
            assign disp_if[j].clr_val = disp_clr[j];
            assign disp_if[j].set_ok = s_q.set_en[j];
            assign disp_if[j].clr_ok = s_q.clr_en[j];
            assign disp_q[j] = disp_if[j].q;
            set_clear_pulse u_edge (
                .mclk(mclk),
                .resetn(resetn),
                .p(disp_if[j])
            );
        end
    endgenerate

    gate_fine_shift u_shift (
        .mclk(mclk),
        .resetn(resetn),
        .ce(disp_ce),
        .d(disp_q[vid_timing_pkg::SRP_GATE0] |
           disp_q[vid_timing_pkg::SRP_GATE0+1]),
        .shift(disp_gate_shift),
        .q(dgate_shifted)
    );

    always_comb begin
        irq_set = '0;
        irq_clr = '0;
        for (int k = 0; k < vid_timing_pkg::N_IRQ; k++) begin
            irq_clr[k] = wr && s_q.addr ==
                vid_timing_pkg::ADDR_IRQ_CLR_BASE + 8'(k);
        end
        s_d = s_q;
        s_d.hu = 1'b0;
        s_d.wr_prev = write_strobe_n;
        if (ale) begin
            s_d.addr = ad_in;
        end
        if (wr && s_q.addr == vid_timing_pkg::ADDR_PLL_CTRL) begin
            s_d.pll = wdat9[7:0];
        end
        if (wr && s_q.addr[6:0] == vid_timing_pkg::ADDR_ACQ_IRQ_CMP) begin
            s_d.acq_cmp = wdat9[LINE_W-1:0];
        end
        // acquisition horizontal
        if (acq_ce) begin
            s_d.r1_prev = acq_line_reset_pulse;
            s_d.vi1_prev = acq_field_pulse;
            s_d.ovl_prev = overlay_window_input;
            s_d.acq_pix = acq_adv ? '0 : s_q.acq_pix + 1'b1;
        end
        s_d.hi = s_q.acq_pix == acq_hpos;
        if (ovl_rise) begin
            s_d.orise = s_q.acq_pix;
            irq_set[vid_timing_pkg::IRQ_OVL] =
                s_q.pll[vid_timing_pkg::PLL_OVL_IRQ_BIT];
        end
        if (ovl_fall) begin
            s_d.ofall = s_q.acq_pix;
        end
        // acquisition vertical, advanced once per acquisition line
        if (acq_adv) begin
            s_d.acq_line = s_q.acq_line + 1'b1;
            if (s_q.win && s_q.acq_line == acq_win_close) begin
                s_d.win = 1'b0;
                if (!s_q.seen) begin
                    s_d.acq_line = '0;
                    s_d.aflc = s_q.acq_line;
                end
            end else if (!s_q.win && s_q.acq_line == acq_win_open) begin
                s_d.win = 1'b1;
                s_d.seen = 1'b0;
            end
            if (s_d.acq_line == s_q.acq_cmp) begin
                irq_set[vid_timing_pkg::IRQ_ACQ_LINE] =
                    s_q.pll[vid_timing_pkg::PLL_ACQ_LINE_IRQ_BIT];
            end
            if (s_q.acq_line == gate_start_line) begin
                s_d.gate_cnt = '0;
                s_d.gate_en = 1'b1;
            end else if (s_q.gate_en) begin
                if (s_q.gate_cnt == gate_stop_count) begin
                    s_d.gate_en = 1'b0;
                    irq_set[vid_timing_pkg::IRQ_GATE] =
                        s_q.pll[vid_timing_pkg::PLL_GATE_IRQ_BIT];
                end else begin
                    s_d.gate_cnt = s_q.gate_cnt + 1'b1;
                end
            end
        end
        if (vi1_hit) begin
            s_d.afep = s_q.acq_pix;
            s_d.aflc = s_q.acq_line;
            s_d.acq_line = '0;
            s_d.seen = 1'b1;
        end
        // display side
        if (disp_ce) begin
            s_d.r2_prev = disp_line_reset_pulse;
            s_d.vi2_prev = disp_field_pulse;
            s_d.disp_pix = disp_adv ? '0 : s_q.disp_pix + 1'b1;
        end
        if (disp_adv) begin
            s_d.hu = 1'b1;
            // staged enables switch together, once per line
            s_d.set_en = disp_set_en;
            s_d.clr_en = disp_clr_en;
            s_d.disp_line = s_q.disp_line + 1'b1;
            if (s_d.disp_line == disp_line_irq_cmp) begin
                irq_set[vid_timing_pkg::IRQ_DISP] = 1'b1;
            end
        end
        if (wr && s_q.addr == vid_timing_pkg::ADDR_DISP_LINE_RST) begin
            s_d.disp_line = '0;
        end
        if (vi2_rise) begin
            s_d.dfep = s_q.disp_pix;
            s_d.dflc = s_q.disp_line;
        end
        if (snap) begin
            s_d.afep = s_q.acq_pix;
            s_d.aflc = s_q.acq_line;
            s_d.dfep = s_q.disp_pix;
            s_d.dflc = s_q.disp_line;
        end
        s_d.gates = acq_q;
        s_d.mute = disp_q[vid_timing_pkg::SRP_MUTE];
        s_d.sync = disp_q[vid_timing_pkg::SRP_SYNC];
        s_d.fkey = |disp_q[vid_timing_pkg::SRP_KEY0 +: 3];
        s_d.rdstb = dgate_shifted;
        // a new event beats a clear in the same cycle
        s_d.irq = (s_q.irq & ~irq_clr) | irq_set;
        s_d.it1 = |(s_d.irq & vid_timing_pkg::IRQ_ACQ_MASK);
        s_d.it2 = s_d.irq[vid_timing_pkg::IRQ_DISP];
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.pll <= vid_timing_pkg::PLL_CTRL_RST;
            s_q.acq_cmp <= vid_timing_pkg::ACQ_IRQ_CMP_RST;
            s_q.wr_prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign clamp_control_out = s_q.gates[0];
    assign field_mem_write_strobe = s_q.gates[1];
    assign field_mem_input_strobe = s_q.gates[2];
    assign acq_horizontal_pulse = s_q.hi;
    assign disp_horizontal_pulse = s_q.hu;
    assign video_mute_window = s_q.mute;
    assign disp_sync_output = s_q.sync;
    assign frame_key_window = s_q.fkey;
    assign field_mem_read_strobe = s_q.rdstb;
    assign acq_irq_out = s_q.it1;
    assign disp_irq_out = s_q.it2;
    assign acq_field_edge_position = s_q.afep;
    assign acq_field_line_capture = s_q.aflc;
    assign disp_field_edge_position = s_q.dfep;
    assign disp_field_line_capture = s_q.dflc;
    assign overlay_rise_position = s_q.orise;
    assign overlay_fall_position = s_q.ofall;
    assign interrupt_status_source = s_q.irq;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_acq_pix_wrap: assert property (acq_ce && !r1_rise &&
        s_q.acq_pix == acq_pix_term |=> s_q.acq_pix == '0)
        else $error("acquisition pixel counter missed terminal");
    a_acq_r1_restart: assert property (r1_rise |=>
        s_q.acq_pix == '0)
        else $error("line reset rise did not restart pixel count");
    a_hpos_pulse: assert property ($past(s_q.acq_pix) ==
        $past(acq_hpos) |-> acq_horizontal_pulse)
        else $error("horizontal pulse absent at programmed position");
    a_field_capture: assert property (vi1_hit && !snap |=>
        acq_field_edge_position == $past(s_q.acq_pix) &&
        s_q.acq_line == '0)
        else $error("field edge position not captured");
    a_snapshot_load: assert property (snap |=>
        disp_field_edge_position == $past(s_q.disp_pix) &&
        acq_field_line_capture == $past(s_q.acq_line))
        else $error("snapshot did not load counts");
    a_ovl_irq: assert property (ovl_rise &&
        s_q.pll[vid_timing_pkg::PLL_OVL_IRQ_BIT] |=>
        interrupt_status_source[vid_timing_pkg::IRQ_OVL] ##1 acq_irq_out)
        else $error("overlay rise did not raise interrupt");
    a_line_irq_off: assert property (
        !s_q.pll[vid_timing_pkg::PLL_ACQ_LINE_IRQ_BIT] &&
        !s_q.irq[vid_timing_pkg::IRQ_ACQ_LINE] |=>
        !s_q.irq[vid_timing_pkg::IRQ_ACQ_LINE])
        else $error("disabled line interrupt was raised");
    a_gate_start: assert property (acq_adv &&
        s_q.acq_line == gate_start_line |=> s_q.gate_en &&
        s_q.gate_cnt == '0)
        else $error("gate enable did not start");
    a_hu_on_restart: assert property (disp_adv |=>
        disp_horizontal_pulse ##1 !disp_horizontal_pulse)
        else $error("display horizontal pulse wrong");
    a_disp_line_rst: assert property (wr &&
        s_q.addr == vid_timing_pkg::ADDR_DISP_LINE_RST |=>
        s_q.disp_line == '0)
        else $error("display line counter not restarted");
    a_irq_set_wins: assert property ((irq_set & irq_clr) != '0 |=>
        (interrupt_status_source & $past(irq_set)) == $past(irq_set))
        else $error("clear overrode simultaneous interrupt");
    a_addr_latch: assert property (ale |=>
        s_q.addr == $past(ad_in))
        else $error("address not latched during ale");

    c_field_edge: cover property (vi1_hit);
    c_window_timeout: cover property (acq_adv && s_q.win && !s_q.seen &&
        s_q.acq_line == acq_win_close);
    c_gate_irq: cover property (irq_set[vid_timing_pkg::IRQ_GATE]);
    c_disp_irq: cover property (disp_irq_out);
endmodule : video_sync_timing_generator

// >>> tb/mcu_bus_model.sv
// Purpose: microcontroller side of the multiplexed write bus
// Assumes: one write at a time, started by the bench just after an edge
// Notes: released bus shows inverted data, never a stale value
`timescale 1ns/1ps
module mcu_bus_model (
    input wire logic mclk,
    output logic ale,
    output logic [7:0] ad_in,
    output logic write_strobe_n
);
    initial begin
        ale = 1'b0;
        ad_in = 8'h00;
        write_strobe_n = 1'b1;
    end
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        ale <= 1'b1;
        ad_in <= a;
        @(posedge mclk);
        ale <= 1'b0;
        ad_in <= d;
        write_strobe_n <= 1'b0;
        @(posedge mclk);
        write_strobe_n <= 1'b1;
        ad_in <= ~d;
        // strobe high for a cycle before any next write
        @(posedge mclk);
    endtask : write
endmodule : mcu_bus_model

// >>> tb/testbench.sv
// Purpose: self-checking bench for the video sync timing generator
// Assumes: both rate enables held high, so counts advance every mclk
// Notes: periods are taken between output rises, free of fixed lag
`timescale 1ns/1ps
module testbench;
    logic mclk = 1'b0, resetn = 1'b0, ext = 1'b0;
    logic acq_lrst = 1'b0, ovl = 1'b0, ale, write_strobe_n;
    logic [7:0] ad_in, ph = 8'h00, ovl_rise, ovl_fall;
    logic [7:0] acq_pix_term = 8'h13, acq_hpos = 8'h03;
    logic [7:0] disp_pix_term = 8'h09;
    logic [2:0][7:0] acq_gate_set = 24'h000002, acq_gate_clr = 24'h000006;
    logic [8:0] acq_win_open = 9'h001, acq_win_close = 9'h032;
    logic [8:0] gate_start_line = 9'h002, gate_stop_count = 9'h004;
    logic [8:0] disp_line_irq_cmp = 9'h005;
    logic [6:0][7:0] disp_set = '0, disp_clr = '0;
    logic [6:0] disp_set_en = '0, disp_clr_en = '0;
    logic [1:0] disp_gate_shift = 2'h0;
    logic clamp, acq_hp, disp_hp, acq_irq, disp_irq;
    logic [3:0] irq_src;
    logic mute;
    logic [8:0] aflc;
    int mismatches = 0, n_tests = 0, n, m;
    wire logic [4:0] mon = {disp_irq, acq_irq, clamp, disp_hp, acq_hp};

    always #5 mclk = ~mclk;
    // line reset every 30 cycles while ext runs
    always @(posedge mclk) begin
        ph <= (ph == 8'h1d || !ext) ? 8'h00 : ph + 8'h01;
        acq_lrst <= ext && ph == 8'h00;
    end

    mcu_bus_model i_mcu (.mclk, .ale, .ad_in, .write_strobe_n);
    video_sync_timing_generator i_dut (
        .mclk, .resetn, .acq_ce(1'b1), .disp_ce(1'b1), .ale, .ad_in,
        .write_strobe_n, .acq_line_reset_pulse(acq_lrst),
        .acq_field_pulse(1'b0), .overlay_window_input(ovl),
        .disp_line_reset_pulse(1'b0), .disp_field_pulse(1'b0),
        .acq_pix_term, .acq_hpos, .acq_gate_set, .acq_gate_clr,
        .acq_win_open, .acq_win_close, .gate_start_line, .gate_stop_count,
        .disp_pix_term, .disp_set, .disp_clr, .disp_set_en, .disp_clr_en,
        .disp_gate_shift, .disp_line_irq_cmp, .clamp_control_out(clamp),
        .field_mem_write_strobe(), .field_mem_input_strobe(),
        .acq_horizontal_pulse(acq_hp), .disp_horizontal_pulse(disp_hp),
        .video_mute_window(mute), .disp_sync_output(), .frame_key_window(),
        .field_mem_read_strobe(), .acq_irq_out(acq_irq),
        .disp_irq_out(disp_irq), .acq_field_edge_position(),
        .acq_field_line_capture(aflc), .disp_field_edge_position(),
        .disp_field_line_capture(), .overlay_rise_position(ovl_rise),
        .overlay_fall_position(ovl_fall), .interrupt_status_source(irq_src)
    );

    task automatic give_verdict();
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // counts cycles while a monitored output stays at v
    task automatic run(input int b, input logic v, output int k);
        k = 0;
        while (mon[b] === v) begin
            @(negedge mclk);
            k++;
            if (k > 3000) begin
                mismatches++;
                give_verdict();
            end
        end
    endtask : run

    task automatic period(input int b, input int hi, input int len);
        run(b, 1'b1, n);
        run(b, 1'b0, n);
        run(b, 1'b1, n);
        run(b, 1'b0, m);
        cmp(9'(n), 9'(hi));
        cmp(9'(n + m), 9'(len));
    endtask : period

    task automatic t_lines();
        period(0, 1, 20);
        period(1, 1, 10);
        @(posedge mclk);
        acq_pix_term <= 8'hff;
        ext <= 1'b1;
        // let the old line regime die out before measuring
        repeat (40) @(posedge mclk);
        period(0, 1, 30);
        ext <= 1'b0;
        acq_pix_term <= 8'h13;
    endtask : t_lines

    task automatic t_gate();
        period(2, 4, 20);
        acq_gate_set[0] <= 8'h05;
        acq_gate_clr[0] <= 8'h05;
        repeat (5) @(negedge mclk);
        m = 0;
        repeat (60) begin
            @(negedge mclk);
            m += (clamp !== 1'b0);
        end
        cmp(9'(m), 9'h000);
    endtask : t_gate

    task automatic t_overlay();
        i_mcu.write(8'h3d, 8'h04);
        run(0, 1'b0, n);
        @(posedge mclk);
        ovl <= 1'b1;
        repeat (5) @(posedge mclk);
        ovl <= 1'b0;
        repeat (4) @(negedge mclk);
        cmp({1'b0, ovl_fall - ovl_rise}, 9'h005);
        cmp({8'h00, irq_src[2]}, 9'h001);
        cmp({8'h00, acq_irq}, 9'h001);
        i_mcu.write(8'h32, 8'h00);
        @(negedge mclk);
        cmp({5'h00, irq_src[2:0], acq_irq}, 9'h000);
    endtask : t_overlay

    task automatic t_mute();
        @(posedge mclk);
        disp_set[0] <= 8'h02;
        disp_clr[0] <= 8'hff;
        disp_set_en <= 7'h01;
        disp_clr_en <= 7'h01;
        repeat (30) @(negedge mclk);
        m = 0;
        repeat (40) begin
            @(negedge mclk);
            m += (mute !== 1'b1);
        end
        cmp(9'(m), 9'h000);
    endtask : t_mute

    task automatic t_irq_lines();
        i_mcu.write(8'h40, 8'h03);
        i_mcu.write(8'h3d, 8'h02);
        run(3, 1'b0, n);
        cmp({8'h00, irq_src[0]}, 9'h001);
        i_mcu.write(8'h30, 8'h00);
        @(negedge mclk);
        cmp({8'h00, irq_src[0]}, 9'h000);
        i_mcu.write(8'h14, 8'h00);
        i_mcu.write(8'h33, 8'h00);
        @(negedge mclk);
        run(4, 1'b0, n);
        cmp({8'h00, n >= 30 && n <= 60}, 9'h001);
        cmp({8'h00, irq_src[3]}, 9'h001);
        // window closed at line 50 with no field edge seen
        cmp(aflc, 9'h032);
    endtask : t_irq_lines

    initial begin
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        t_lines();
        t_gate();
        t_overlay();
        t_irq_lines();
        t_mute();
        give_verdict();
    end
endmodule : testbench
